// ---- bps_burst_status.sv ----
// Burst preamble detector with read-only type and length status registers
`timescale 1ns/1ps
`default_nettype none

// Function
// - Detect burst by fixed sync words A, B
// - Latch type and length into four status registers
// - Type word high byte first, low byte next
// - Length word high byte first, low byte next
// - Classify five-bit payload type code
// - Type word bits six, five read zero
// - Type word bit seven flags payload errors
// - Pass dependent bits, stream number reads zero
// - Length word gives payload length in bits
// - Host selects page zero before reading
// - Host reads over selected serial control port
module bps_burst_status #(
  parameter int WORD_WIDTH = bps_pkg::WORD_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire bps_pkg::bps_word_t sub_word,
  input wire bps_pkg::bps_req_t reg_req,
  output bps_pkg::bps_rsp_t reg_rsp,
  output logic reg_hit,
  output logic write_ignored,
  output logic burst_seen,
  output logic burst_valid,
  output bps_pkg::bps_info_t burst_info
);
  import bps_pkg::*;

  if (WORD_WIDTH != WORD_W) begin : g_width_check
    $error("bps_burst_status: WORD_WIDTH must be 16");
  end

  if (STREAM_MSB != WORD_W - 1) begin : g_stream_check
    $error("bps_burst_status: stream field must end at the top bit");
  end

  if (TYPE_CODE_MSB - TYPE_CODE_LSB != 4) begin : g_code_check
    $error("bps_burst_status: type code must be five bits");
  end

  if (FILL_MSB + 1 != ERROR_BIT) begin : g_fill_check
    $error("bps_burst_status: fill field must sit below the error flag");
  end

  if (DEP_LSB != ERROR_BIT + 1) begin : g_dep_low_check
    $error("bps_burst_status: dependent field must follow the error flag");
  end

  if (DEP_MSB + 1 != STREAM_LSB) begin : g_dep_high_check
    $error("bps_burst_status: stream field must follow dependent field");
  end

  if (ERROR_BIT >= DEP_LSB) begin : g_error_check
    $error("bps_burst_status: error flag must sit in the low byte");
  end

  typedef struct packed {
    bps_state_t state;
    logic [15:0] type_hold;
    logic [15:0] type_word;
    logic [15:0] length_word;
    logic valid;
    logic seen;
    bps_rsp_t rsp;
    logic wr_ign;
  } bps_regs_t;

  bps_regs_t r;
  bps_regs_t next_r;

  function automatic logic is_status_addr(input logic [6:0] a);
    return (a >= BURST_TYPE_WORD_HIGH_ADDR) &&
           (a <= BURST_LENGTH_WORD_LOW_ADDR);
  endfunction : is_status_addr

  // Fill and stream fields forced to zero
  function automatic logic [15:0] clean_type(input logic [15:0] w);
    logic [15:0] c;
    c = w;
    c[FILL_MSB:FILL_LSB] = FILL_ZERO;
    c[STREAM_MSB:STREAM_LSB] = STREAM_ZERO;
    return c;
  endfunction : clean_type

  // Byte lanes of a 16-bit status word
  function automatic logic [7:0] high_byte(input logic [15:0] w);
    return w[15:8];
  endfunction : high_byte

  function automatic logic [7:0] low_byte(input logic [15:0] w);
    return w[7:0];
  endfunction : low_byte

  // Status byte for one address; unmapped reads idle
  function automatic logic [7:0] read_byte(input logic [6:0] a,
    input logic [15:0] tw, input logic [15:0] lw);
    logic [7:0] b;
    b = READ_IDLE;
    case (a)
      BURST_TYPE_WORD_HIGH_ADDR: begin
        b = high_byte(tw);
      end
      BURST_TYPE_WORD_LOW_ADDR: begin
        b = low_byte(tw);
      end
      BURST_LENGTH_WORD_HIGH_ADDR: begin
        b = high_byte(lw);
      end
      BURST_LENGTH_WORD_LOW_ADDR: begin
        b = low_byte(lw);
      end
      default: begin
        b = READ_IDLE;
      end
    endcase
    return b;
  endfunction : read_byte

  // Codes with no defined payload format
  function automatic logic is_reserved_code(input logic [4:0] c);
    return (c == TYPE_RSVD_A) ||
           (c == TYPE_RSVD_B) ||
           (c >= TYPE_RSVD_FROM);
  endfunction : is_reserved_code

  // Decoded view of the held type word
  function automatic bps_info_t classify(input logic [15:0] w);
    bps_info_t i;
    logic [4:0] c;
    c = w[TYPE_CODE_MSB:TYPE_CODE_LSB];
    i.type_code = c;
    i.error = w[ERROR_BIT];
    i.is_null = (c == TYPE_NULL);
    i.is_pause = (c == TYPE_PAUSE);
    i.is_reserved = is_reserved_code(c);
    return i;
  endfunction : classify

  logic page_ok;
  logic addr_ok;

  assign page_ok = (reg_req.page == STATUS_PAGE);
  assign addr_ok = page_ok && is_status_addr(reg_req.addr);

  always_comb begin
    next_r = r;
    next_r.seen = 1'b0;
    next_r.wr_ign = reg_req.wr && addr_ok;
    next_r.rsp.valid = reg_req.rd;
    next_r.rsp.data = READ_IDLE;

    if (sub_word.valid) begin
      case (r.state)
        BPS_SEEK_A: begin
          if (sub_word.data == SYNC_WORD_A) begin
            next_r.state = BPS_SEEK_B;
          end
        end
        BPS_SEEK_B: begin
          if (sub_word.data == SYNC_WORD_B) begin
            next_r.state = BPS_GET_TYPE;
          end else if (sub_word.data == SYNC_WORD_A) begin
            next_r.state = BPS_SEEK_B;
          end else begin
            next_r.state = BPS_SEEK_A;
          end
        end
        BPS_GET_TYPE: begin
          next_r.type_hold = sub_word.data;
          next_r.state = BPS_GET_LENGTH;
        end
        BPS_GET_LENGTH: begin
          // Both words commit in one edge
          next_r.type_word = clean_type(r.type_hold);
          next_r.length_word = sub_word.data;
          next_r.valid = 1'b1;
          next_r.seen = 1'b1;
          next_r.state = BPS_SEEK_A;
        end
        default: begin
          next_r.state = BPS_SEEK_A;
        end
      endcase
    end

    // Reads return the held values; writes never alter them
    if (reg_req.rd && page_ok) begin
      next_r.rsp.data = read_byte(reg_req.addr, r.type_word,
                                  r.length_word);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r.state <= BPS_SEEK_A;
      r.type_hold <= TYPE_WORD_RESET;
      r.type_word <= TYPE_WORD_RESET;
      r.length_word <= LENGTH_WORD_RESET;
      r.valid <= 1'b0;
      r.seen <= 1'b0;
      r.rsp <= '0;
      r.wr_ign <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rsp = r.rsp;
  assign reg_hit = addr_ok;
  assign write_ignored = r.wr_ign;
  assign burst_seen = r.seen;
  assign burst_valid = r.valid;
  // Decoded from the held word, so it moves only on a commit
  assign burst_info = classify(r.type_word);

endmodule : bps_burst_status
`default_nettype wire

// ---- bps_burst_status_asserts.sv ----
// Checker for the burst preamble status block
`timescale 1ns/1ps
`default_nettype none
module bps_chk import bps_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire bps_pkg::bps_word_t sub_word,
  input wire bps_pkg::bps_req_t reg_req,
  input wire bps_pkg::bps_rsp_t reg_rsp,
  input wire logic reg_hit,
  input wire logic write_ignored,
  input wire logic burst_seen,
  input wire logic burst_valid,
  input wire bps_pkg::bps_info_t burst_info
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_RSP: assert property (reg_req.rd |=> reg_rsp.valid)
    else $error("read not answered");
  AST_HIT: assert property (reg_hit == (reg_req.page == STATUS_PAGE &&
    reg_req.addr inside {[7'h29:7'h2c]}))
    else $error("hit decode wrong");
  AST_WIGN: assert property (reg_req.wr && reg_hit |=> write_ignored)
    else $error("write not flagged");
  AST_OFF: assert property (reg_req.rd && !reg_hit |=> reg_rsp.data == 8'h00)
    else $error("unmapped read not zero");
  AST_FILL: assert property (reg_req.rd && reg_hit && reg_req.addr == 7'h2a
    |=> reg_rsp.data[6:5] == 2'h0)
    else $error("fill bits set");
  AST_STRM: assert property (reg_req.rd && reg_hit && reg_req.addr == 7'h29
    |=> reg_rsp.data[7:5] == 3'h0)
    else $error("stream number set");
  AST_HOLD: assert property (!burst_seen |-> $stable(burst_info))
    else $error("status moved without burst");
  AST_SEEN: assert property (burst_seen |-> $past(sub_word.valid) && burst_valid)
    else $error("burst without length word");
  AST_RSVD: assert property (burst_info.is_reserved == (burst_info.type_code
    inside {5'h02, 5'h0a} || burst_info.type_code[4]))
    else $error("reserved decode wrong");
endmodule : bps_chk
bind bps_burst_status bps_chk u_chk (.mclk, .rstn, .sub_word, .reg_req,
  .reg_rsp, .reg_hit, .write_ignored, .burst_seen, .burst_valid, .burst_info);
`default_nettype wire

// ---- bps_burst_status_tb.sv ----
// Testbench for the burst preamble status block
`timescale 1ns/1ps
`default_nettype none
module bps_burst_status_tb;
  import bps_pkg::*;
  logic mclk = 0;
  logic rstn = 0;
  bps_word_t sub_word = '0;
  bps_req_t reg_req;
  bps_rsp_t reg_rsp;
  bps_info_t burst_info;
  logic reg_hit, write_ignored, burst_seen, burst_valid;
  logic [8:0] r;
  int failures = 0;
  int compares = 0;
  always #2 mclk = ~mclk;
  bps_burst_status dut (.mclk, .rstn, .sub_word, .reg_req, .reg_rsp,
    .reg_hit, .write_ignored, .burst_seen, .burst_valid, .burst_info);
  bps_host host (.mclk, .reg_req, .reg_rsp);
  task chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task put(input logic [15:0] w);
    @(posedge mclk);
    #1;
    sub_word = '{1'b1, w};
    @(posedge mclk);
    #1;
    sub_word = '{1'b0, ~w};
  endtask : put
  task send(input logic [15:0] t, input logic [15:0] l);
    put(SYNC_WORD_A);
    put(SYNC_WORD_B);
    put(t);
    put(l);
  endtask : send
  task t_burst;
    put(SYNC_WORD_A);
    send(16'hffeb, 16'h8001);
    chk(9'(burst_seen), 9'h001);
    host.xfer(1'b0, 2'h0, 7'h29, r);
    chk(r, 9'h11f);
    host.xfer(1'b0, 2'h0, 7'h2a, r);
    chk(r, 9'h18b);
    host.xfer(1'b0, 2'h0, 7'h2b, r);
    chk(r, 9'h180);
    host.xfer(1'b0, 2'h0, 7'h2c, r);
    chk(r, 9'h101);
    chk(9'({burst_valid, burst_info.error, burst_info.type_code}),
      9'h06b);
    $display("t_burst done");
  endtask : t_burst
  task t_ro;
    host.xfer(1'b1, 2'h0, 7'h2a, r);
    chk(9'(write_ignored), 9'h001);
    put(SYNC_WORD_B);
    put(16'h1234);
    put(16'h5678);
    host.xfer(1'b0, 2'h0, 7'h2a, r);
    chk(r, 9'h18b);
    host.xfer(1'b0, 2'h1, 7'h29, r);
    chk(r, 9'h100);
    host.xfer(1'b0, 2'h0, 7'h2d, r);
    chk(r, 9'h100);
    $display("t_ro done");
  endtask : t_ro
  task t_codes;
    logic [4:0] c[6];
    c = '{5'h00, 5'h03, 5'h02, 5'h0a, 5'h10, 5'h1f};
    foreach (c[i]) begin
      send({11'h000, c[i]}, 16'h0010);
      chk(9'({burst_info.is_null, burst_info.is_pause,
        burst_info.is_reserved}), 9'({c[i] == 5'h00, c[i] == 5'h03,
        c[i] inside {5'h02, 5'h0a} || c[i][4]}));
    end
    $display("t_codes done");
  endtask : t_codes
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (2000) @(posedge mclk);
    failures++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rstn = 1;
    t_burst;
    t_ro;
    t_codes;
    test_done;
  end
endmodule : bps_burst_status_tb
`default_nettype wire

// ---- bps_host.sv ----
// Host model issuing register requests on the strobe port
`timescale 1ns/1ps
`default_nettype none
module bps_host (
  input wire logic mclk,
  output bps_pkg::bps_req_t reg_req,
  input wire bps_pkg::bps_rsp_t reg_rsp
);
  initial reg_req = '0;
  // One strobe cycle, answer taken at the next edge
  task xfer(input logic w, input logic [1:0] pg, input logic [6:0] a,
    output logic [8:0] r);
    // Idle cycle first, so back-to-back calls never collide
    @(posedge mclk);
    #1;
    reg_req = '{~w, w, pg, a};
    @(posedge mclk);
    #1;
    r = {reg_rsp.valid, reg_rsp.data};
    reg_req = '{1'b0, 1'b0, ~pg, ~a};
  endtask : xfer
endmodule : bps_host
`default_nettype wire

// ---- bps_pkg.sv ----
// Package for the burst preamble status block: map, codes and carriers
package bps_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam int PAGE_W = 2;

  localparam logic [15:0] SYNC_WORD_A = 16'hf872;
  localparam logic [15:0] SYNC_WORD_B = 16'h4e1f;

  localparam logic [1:0] STATUS_PAGE = 2'h0;
  localparam logic [6:0] PAGE_SELECT_ADDR = 7'h7f;
  localparam logic [6:0] BURST_TYPE_WORD_HIGH_ADDR = 7'h29;
  localparam logic [6:0] BURST_TYPE_WORD_LOW_ADDR = 7'h2a;
  localparam logic [6:0] BURST_LENGTH_WORD_HIGH_ADDR = 7'h2b;
  localparam logic [6:0] BURST_LENGTH_WORD_LOW_ADDR = 7'h2c;

  localparam logic [15:0] TYPE_WORD_RESET = 16'h0000;
  localparam logic [15:0] LENGTH_WORD_RESET = 16'h0000;
  localparam logic [7:0] READ_IDLE = 8'h00;

  localparam int TYPE_CODE_LSB = 0;
  localparam int TYPE_CODE_MSB = 4;
  localparam int FILL_LSB = 5;
  localparam int FILL_MSB = 6;
  localparam int ERROR_BIT = 7;
  localparam int DEP_LSB = 8;
  localparam int DEP_MSB = 12;
  localparam int STREAM_LSB = 13;
  localparam int STREAM_MSB = 15;

  localparam logic [4:0] TYPE_NULL = 5'h00;
  localparam logic [4:0] TYPE_RSVD_A = 5'h02;
  localparam logic [4:0] TYPE_PAUSE = 5'h03;
  localparam logic [4:0] TYPE_RSVD_B = 5'h0a;
  localparam logic [4:0] TYPE_RSVD_FROM = 5'h10;
  localparam logic [2:0] STREAM_ZERO = 3'h0;
  localparam logic [1:0] FILL_ZERO = 2'h0;

  typedef enum logic [1:0] {
    BPS_SEEK_A = 2'b00,
    BPS_SEEK_B = 2'b01,
    BPS_GET_TYPE = 2'b10,
    BPS_GET_LENGTH = 2'b11
  } bps_state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } bps_word_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] page;
    logic [6:0] addr;
  } bps_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bps_rsp_t;

  typedef struct packed {
    logic is_null;
    logic is_pause;
    logic is_reserved;
    logic error;
    logic [4:0] type_code;
  } bps_info_t;

endpackage : bps_pkg
